// ---- hw/fec_top.sv ----
// Error counters, counter update timing and loopback routing with APB register access
//
// Functional notes
// - Sync select: framing-bit errors or multiframe losses
// - T1 excess-zero select adds excess zeros
// - Line-code count high 42h, low companion
// - Path code count at 44h and 45h
// - Out-of-sync count high 46h, low companion
// - E-bit count at 48h and 49h
// - Connected only when pin high, bit zero
// - Separated path uses external digital pins
// - Local loop: transmitted data replaces received
// - Remote loop: received data retransmitted on line
// - Payload loop: transmit timed by recovered clock
// - T1 payload loop: 192 bits, overhead regenerated
// - E1 payload loop: 248 bits, overhead regenerated
// - Framer loop: T1 sends all-ones, E1 normal
// - Framer loop ignores rx pins, tx timing
// - Channel loop bit sources tx from rx
// - Update latches counts and clears counters
// - Update each second or 333/500 frames
// - E1 select: bipolar or code violations
`timescale 1ns/1ps
module fec_top #(
    parameter int SECOND_CYCLES = fec_pkg::SECOND_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic t1_mode,
    input wire logic frame_tick,
    input wire fec_pkg::fec_events_t line_events,
    input wire logic line_mux_control,
    input wire fec_pkg::fec_pair_t framer_tx,
    input wire fec_pkg::fec_pair_t liu_rx,
    input wire fec_pkg::fec_pair_t rx_pins_in,
    input wire fec_pkg::fec_pair_t tx_pins_in,
    output fec_pkg::fec_pair_t framer_rx,
    output fec_pkg::fec_pair_t liu_tx,
    output fec_pkg::fec_pair_t tx_pins_out,
    output fec_pkg::fec_pair_t rx_pins_out,
    output fec_pkg::fec_route_t route,
    output logic line_connected
);

    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    if (SECOND_CYCLES < 2 || SECOND_CYCLES > 32'h7fffffff) begin : g_bad_param
        $error("SECOND_CYCLES out of range");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] err_cfg;
        logic [4:0] loop_ctrl;
        logic [7:0] chan_loop;
        logic [3:0][15:0] count;
        logic [3:0][15:0] held;
        logic [31:0] second_cnt;
        logic [8:0] frame_cnt;
        logic [31:0] rdata;
        logic connected;
        logic ones_phase;
        fec_pkg::fec_pair_t framer_rx;
        fec_pkg::fec_pair_t liu_tx;
        fec_pkg::fec_pair_t tx_pins_out;
        fec_pkg::fec_pair_t rx_pins_out;
        fec_pkg::fec_route_t route;
    } fec_state_t;

    fec_state_t st_r;
    fec_state_t st_nxt;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Holding at all ones keeps a flooded line from reading as a clean one
    function automatic logic [15:0] sat_inc(input logic [15:0] value, input logic inc);
        if (inc && value != 16'hffff) begin
            return value + 16'h0001;
        end
        return value;
    endfunction

    function automatic logic reg_mapped(input logic [7:0] idx);
        return idx >= fec_pkg::IDX_ERR_CFG && idx <= fec_pkg::IDX_CHAN_LOOP_1;
    endfunction

    function automatic logic [7:0] reg_read(input fec_state_t s, input logic [7:0] idx);
        case (idx)
            fec_pkg::IDX_ERR_CFG: return s.err_cfg;
            fec_pkg::IDX_LCV_HIGH: return s.held[fec_pkg::CNT_LCV][15:8];
            fec_pkg::IDX_LCV_LOW: return s.held[fec_pkg::CNT_LCV][7:0];
            fec_pkg::IDX_PCV_HIGH: return s.held[fec_pkg::CNT_PCV][15:8];
            fec_pkg::IDX_PCV_LOW: return s.held[fec_pkg::CNT_PCV][7:0];
            fec_pkg::IDX_FOS_HIGH: return s.held[fec_pkg::CNT_FOS][15:8];
            fec_pkg::IDX_FOS_LOW: return s.held[fec_pkg::CNT_FOS][7:0];
            fec_pkg::IDX_EB_HIGH: return s.held[fec_pkg::CNT_EB][15:8];
            fec_pkg::IDX_EB_LOW: return s.held[fec_pkg::CNT_EB][7:0];
            fec_pkg::IDX_LOOP_CTRL: return {3'h0, s.loop_ctrl};
            fec_pkg::IDX_CHAN_LOOP_1: return s.chan_loop;
            default: return 8'h00;
        endcase
    endfunction

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic [7:0] idx;
    logic setup_phase;
    logic wr_take;
    logic [31:0] second_last;

    assign idx = paddr[9:2];
    assign setup_phase = psel && !penable;
    assign wr_take = psel && penable && pwrite && pstrb[0] && reg_mapped(idx) && paddr[31:10] == 22'h0;
    assign second_last = 32'(SECOND_CYCLES - 1);

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic [7:0] cfg_new;
    logic manual_count_update_rise;
    logic auto_due;
    logic update;
    logic [8:0] fast_frames;
    logic [3:0] inc;
    logic lb_local;
    logic lb_remote;
    logic lb_payload;
    logic lb_framer;
    fec_pkg::fec_pair_t rx_line;
    fec_pkg::fec_pair_t tx_data;
    fec_pkg::fec_pair_t all_ones;

    always_comb begin
        st_nxt = st_r;
        cfg_new = st_r.err_cfg;
        manual_count_update_rise = 1'b0;
        auto_due = 1'b0;
        update = 1'b0;
        fast_frames = t1_mode ? fec_pkg::T1_FAST_FRAMES : fec_pkg::E1_FAST_FRAMES;
        inc = 4'h0;

        // Register writes take effect at the access edge
        if (wr_take) begin
            case (idx)
                fec_pkg::IDX_ERR_CFG: begin
                    cfg_new = pwdata[7:0] & fec_pkg::MASK_ERR_CFG;
                    st_nxt.err_cfg = cfg_new;
                end
                fec_pkg::IDX_LOOP_CTRL: begin
                    st_nxt.loop_ctrl = pwdata[4:0];
                end
                fec_pkg::IDX_CHAN_LOOP_1: begin
                    st_nxt.chan_loop = pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        // A manual update fires only on a written 0 to 1 change of its bit
        manual_count_update_rise = wr_take && idx == fec_pkg::IDX_ERR_CFG &&
                    cfg_new[fec_pkg::BIT_MANUAL_UPDATE] && !st_r.err_cfg[fec_pkg::BIT_MANUAL_UPDATE];

        // Update interval timers
        if (st_r.second_cnt >= second_last) begin
            st_nxt.second_cnt = 32'h0;
            if (!st_r.err_cfg[fec_pkg::BIT_INTERVAL_SEL]) begin
                auto_due = 1'b1;
            end
        end else begin
            st_nxt.second_cnt = st_r.second_cnt + 32'h1;
        end
        if (frame_tick) begin
            if (st_r.frame_cnt >= fast_frames - 9'd1) begin
                st_nxt.frame_cnt = 9'h0;
                if (st_r.err_cfg[fec_pkg::BIT_INTERVAL_SEL]) begin
                    auto_due = 1'b1;
                end
            end else begin
                st_nxt.frame_cnt = st_r.frame_cnt + 9'd1;
            end
        end
        update = st_r.err_cfg[fec_pkg::BIT_ACCUM_SRC_SEL] ? manual_count_update_rise : auto_due;

        // Event selection per counter
        if (t1_mode) begin
            inc[fec_pkg::CNT_LCV] = line_events.bpv ||
                (st_r.err_cfg[fec_pkg::BIT_EXCESS_ZERO_SEL] && line_events.excess_zero);
        end else begin
            inc[fec_pkg::CNT_LCV] = st_r.err_cfg[fec_pkg::BIT_E1_VIOL_SEL] ?
                line_events.code_viol : line_events.bpv;
        end
        inc[fec_pkg::CNT_PCV] = line_events.crc_err ||
            (st_r.err_cfg[fec_pkg::BIT_FS_ERR_ENABLE] && line_events.fs_bit_err);
        inc[fec_pkg::CNT_FOS] = st_r.err_cfg[fec_pkg::BIT_MF_SYNC_SEL] ?
            line_events.mf_sync_loss : line_events.frame_bit_err;
        inc[fec_pkg::CNT_EB] = line_events.e_bit;

        // An event in the update cycle opens the next interval, it is not lost
        for (int i = 0; i < 4; i++) begin
            if (update) begin
                st_nxt.held[i] = st_r.count[i];
                st_nxt.count[i] = {15'h0, inc[i]};
            end else begin
                st_nxt.count[i] = sat_inc(st_r.count[i], inc[i]);
            end
        end

        // Read data is captured in the setup cycle
        if (setup_phase) begin
            st_nxt.rdata = {24'h0, reg_read(st_r, idx)};
        end

        // Loopback routing
        lb_local = st_r.loop_ctrl[fec_pkg::BIT_LOCAL_LOOP];
        lb_remote = st_r.loop_ctrl[fec_pkg::BIT_REMOTE_LOOP];
        lb_payload = st_r.loop_ctrl[fec_pkg::BIT_PAYLOAD_LOOP];
        lb_framer = st_r.loop_ctrl[fec_pkg::BIT_FRAMER_LOOP];
        st_nxt.connected = line_mux_control && !st_r.loop_ctrl[fec_pkg::BIT_LINE_MUX];

        // Separated, each side meets the external digital pins instead
        rx_line = st_r.connected ? liu_rx : rx_pins_in;
        tx_data = st_r.connected ? framer_tx : tx_pins_in;
        st_nxt.ones_phase = !st_r.ones_phase;
        all_ones.pos = st_r.ones_phase;
        all_ones.neg = !st_r.ones_phase;

        // Receive side of the framer
        if (lb_framer) begin
            st_nxt.framer_rx = framer_tx;
        end else if (lb_local) begin
            st_nxt.framer_rx = tx_data;
        end else begin
            st_nxt.framer_rx = rx_line;
        end

        // Transmit line side
        if (lb_remote) begin
            st_nxt.liu_tx = rx_line;
        end else if (lb_framer && t1_mode) begin
            st_nxt.liu_tx = all_ones;
        end else begin
            st_nxt.liu_tx = tx_data;
        end

        st_nxt.tx_pins_out = framer_tx;
        st_nxt.rx_pins_out = liu_rx;

        // Clocking and payload selects for the framer core
        st_nxt.route.framer_tx_from_rx_clock = lb_payload;
        st_nxt.route.framer_rx_on_tx_clock = lb_framer;
        st_nxt.route.jitter_atten_in_loop = lb_local;
        st_nxt.route.payload_loop_active = lb_payload;
        st_nxt.route.overhead_regenerate = lb_payload;
        st_nxt.route.tx_inputs_ignored = lb_payload || lb_remote;
        if (!lb_payload) begin
            st_nxt.route.payload_bits = 8'h00;
        end else if (t1_mode) begin
            st_nxt.route.payload_bits = fec_pkg::T1_PAYLOAD_BITS;
        end else begin
            st_nxt.route.payload_bits = fec_pkg::E1_PAYLOAD_BITS;
        end
        st_nxt.route.chan_loop = st_r.chan_loop;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.err_cfg <= fec_pkg::RST_ERR_CFG;
            st_r.loop_ctrl <= fec_pkg::RST_LOOP_CTRL;
            st_r.chan_loop <= fec_pkg::RST_CHAN_LOOP;
            st_r.count <= {4{fec_pkg::RST_COUNT}};
            st_r.held <= {4{fec_pkg::RST_COUNT}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = st_r.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!reg_mapped(idx) || paddr[31:10] != 22'h0 ||
                     (pwrite && idx != fec_pkg::IDX_ERR_CFG && idx != fec_pkg::IDX_LOOP_CTRL &&
                      idx != fec_pkg::IDX_CHAN_LOOP_1));
    assign framer_rx = st_r.framer_rx;
    assign liu_tx = st_r.liu_tx;
    assign tx_pins_out = st_r.tx_pins_out;
    assign rx_pins_out = st_r.rx_pins_out;
    assign route = st_r.route;
    assign line_connected = st_r.connected;

endmodule

// ---- shared/fec_pkg.sv ----
// Shared constants and carrier types for the framer error counter and loopback block
package fec_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_ERR_CFG = 8'h41;
    localparam logic [7:0] IDX_LCV_HIGH = 8'h42;
    localparam logic [7:0] IDX_LCV_LOW = 8'h43;
    localparam logic [7:0] IDX_PCV_HIGH = 8'h44;
    localparam logic [7:0] IDX_PCV_LOW = 8'h45;
    localparam logic [7:0] IDX_FOS_HIGH = 8'h46;
    localparam logic [7:0] IDX_FOS_LOW = 8'h47;
    localparam logic [7:0] IDX_EB_HIGH = 8'h48;
    localparam logic [7:0] IDX_EB_LOW = 8'h49;
    localparam logic [7:0] IDX_LOOP_CTRL = 8'h4a;
    localparam logic [7:0] IDX_CHAN_LOOP_1 = 8'h4b;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_EXCESS_ZERO_SEL = 0;
    localparam int BIT_MF_SYNC_SEL = 1;
    localparam int BIT_FS_ERR_ENABLE = 2;
    localparam int BIT_E1_VIOL_SEL = 3;
    localparam int BIT_ACCUM_SRC_SEL = 4;
    localparam int BIT_INTERVAL_SEL = 5;
    localparam int BIT_MANUAL_UPDATE = 6;
    localparam int BIT_FRAMER_LOOP = 0;
    localparam int BIT_PAYLOAD_LOOP = 1;
    localparam int BIT_REMOTE_LOOP = 2;
    localparam int BIT_LOCAL_LOOP = 3;
    localparam int BIT_LINE_MUX = 4;

    // ****************************************************************
    // Reset values, writable masks and counter indices
    // ****************************************************************
    localparam logic [7:0] RST_ERR_CFG = 8'h00;
    localparam logic [4:0] RST_LOOP_CTRL = 5'h00;
    localparam logic [7:0] RST_CHAN_LOOP = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [7:0] MASK_ERR_CFG = 8'h7f;
    localparam int CNT_LCV = 0;
    localparam int CNT_PCV = 1;
    localparam int CNT_FOS = 2;
    localparam int CNT_EB = 3;

    // ****************************************************************
    // Timing and frame figures
    // ****************************************************************
    localparam int CLK_HZ = 25000000;
    localparam int UPDATE_PERIOD_S = 1;
    localparam int SECOND_CYCLES = CLK_HZ * UPDATE_PERIOD_S;
    localparam logic [8:0] T1_FAST_FRAMES = 9'd333;
    localparam logic [8:0] E1_FAST_FRAMES = 9'd500;
    localparam logic [7:0] T1_PAYLOAD_BITS = 8'd192;
    localparam logic [7:0] E1_PAYLOAD_BITS = 8'd248;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic pos;
        logic neg;
    } fec_pair_t;

    typedef struct packed {
        logic bpv;
        logic code_viol;
        logic excess_zero;
        logic crc_err;
        logic fs_bit_err;
        logic frame_bit_err;
        logic mf_sync_loss;
        logic e_bit;
    } fec_events_t;

    typedef struct packed {
        logic framer_tx_from_rx_clock;
        logic framer_rx_on_tx_clock;
        logic jitter_atten_in_loop;
        logic payload_loop_active;
        logic overhead_regenerate;
        logic tx_inputs_ignored;
        logic [7:0] payload_bits;
        logic [7:0] chan_loop;
    } fec_route_t;

endpackage

// ---- tb/fec_line_model.sv ----
// Line-side partner: frame pulses and a distinct pos/neg pattern on each source pair
`timescale 1ns/1ps
module fec_line_model (
    input wire logic pclk,
    input wire logic presetn,
    output logic frame_tick,
    output fec_pkg::fec_pair_t framer_tx,
    output fec_pkg::fec_pair_t liu_rx,
    output fec_pkg::fec_pair_t rx_pins_in,
    output fec_pkg::fec_pair_t tx_pins_in
);
    logic [1:0] phase_r;
    logic tick_r;
    // Patterns differ pairwise within four cycles, so a misrouted pair always shows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= 2'h0;
            tick_r <= 1'b0;
        end else begin
            phase_r <= phase_r + 2'h1;
            tick_r <= ~tick_r;
        end
    end
    assign frame_tick = tick_r;
    assign framer_tx = phase_r;
    assign liu_rx = ~phase_r;
    assign rx_pins_in = {phase_r[0], phase_r[1]};
    assign tx_pins_in = {~phase_r[0], phase_r[1]};
endmodule

// ---- tb/fec_top_asserts.sv ----
// Concurrent checks on the ports of the counter and loopback block
`timescale 1ns/1ps
module fec_top_asserts #(
    parameter int SECOND_CYCLES = fec_pkg::SECOND_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic pslverr,
    input wire logic t1_mode,
    input wire logic line_mux_control,
    input wire fec_pkg::fec_pair_t framer_tx,
    input wire fec_pkg::fec_pair_t rx_pins_in,
    input wire fec_pkg::fec_pair_t framer_rx,
    input wire fec_pkg::fec_route_t route,
    input wire logic line_connected
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_ro_write;
        s_access ##0 (pwrite && paddr == {22'h0, fec_pkg::IDX_EB_LOW, 2'b00});
    endsequence
    unmapped_err_a: assert property (
        s_access ##0 (paddr == {22'h0, 8'h4c, 2'b00}) |-> pslverr) else $error("unmapped access accepted");
    ro_write_a: assert property (
        s_ro_write |-> pslverr) else $error("count register write accepted");
    line_sep_a: assert property (
        line_connected |-> $past(line_mux_control)) else $error("connected with mux pin low");
    // Separated line: the framer sees the external receive pins, one cycle late
    sep_rx_a: assert property (
        $past(presetn) && !$past(line_connected) && !route.framer_rx_on_tx_clock && !route.jitter_atten_in_loop
        |-> framer_rx == $past(rx_pins_in)) else $error("separated receive path wrong");
    flb_rx_a: assert property (
        route.framer_rx_on_tx_clock |-> framer_rx == $past(framer_tx)) else $error("framer loop ignores tx");
    payload_route_a: assert property (
        route.payload_loop_active |-> route.framer_tx_from_rx_clock && route.tx_inputs_ignored)
        else $error("payload loop timing wrong");
    t1_payload_a: assert property (
        route.payload_loop_active && $past(t1_mode) |-> route.payload_bits == 8'hc0 && route.overhead_regenerate)
        else $error("T1 payload size wrong");
    e1_payload_a: assert property (
        route.payload_loop_active && !$past(t1_mode) |-> route.payload_bits == 8'hf8 && route.overhead_regenerate)
        else $error("E1 payload size wrong");
endmodule
bind fec_top fec_top_asserts #(.SECOND_CYCLES(SECOND_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pslverr(pslverr), .t1_mode(t1_mode), .line_mux_control(line_mux_control), .framer_tx(framer_tx),
    .rx_pins_in(rx_pins_in), .framer_rx(framer_rx), .route(route), .line_connected(line_connected)
);

// ---- tb/framer_error_counters_loopback_bench.sv ----
// Self-checking bench for the error counter and loopback block
`timescale 1ns/1ps
module framer_error_counters_loopback_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, t1_mode = 1'b0, line_mux_control = 1'b1;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'hf;
    logic [7:0] ov, sv;
    logic pready, pslverr, frame_tick, line_connected, last_err;
    fec_pkg::fec_events_t line_events = 8'h00;
    fec_pkg::fec_pair_t framer_tx, liu_rx, rx_pins_in, tx_pins_in, framer_rx, liu_tx, tx_pins_out, rx_pins_out;
    fec_pkg::fec_route_t route;
    int err_count = 0, checks_done = 0, cyc = 0;
    fec_top #(.SECOND_CYCLES(50)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .t1_mode, .frame_tick, .line_events, .line_mux_control, .framer_tx, .liu_rx, .rx_pins_in,
        .tx_pins_in, .framer_rx, .liu_tx, .tx_pins_out, .rx_pins_out, .route, .line_connected
    );
    fec_line_model u_line (.pclk, .presetn, .frame_tick, .framer_tx, .liu_rx, .rx_pins_in, .tx_pins_in);
    assign ov = {framer_rx, liu_tx, tx_pins_out, rx_pins_out};
    assign sv = {framer_tx, liu_rx, rx_pins_in, tx_pins_in};
    always #20 pclk = ~pclk;
    // Ceiling sits well above the saturation fill plus the three interval waits
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            conclude();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // Wait states are up to the slave; only the bench ceiling ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rdat, {24'h0, exp});
    endtask
    task rd16(input logic [7:0] hi, input logic [15:0] exp);
        rd(hi, exp[15:8]);
        rd(hi + 8'h01, exp[7:0]);
    endtask
    task pulse(input int b, input int n);
        repeat (n) begin
            @(posedge pclk);
            line_events <= 8'h01 << b;
        end
        @(posedge pclk);
        line_events <= 8'h00;
    endtask
    // Same event mix every round; only mode and selects change what is tallied
    task round(input logic t1, input logic [7:0] cfg, input logic [15:0] lcv, pcv, sync_loss_count_bits, eb);
        t1_mode <= t1;
        apb(1'b1, fec_pkg::IDX_ERR_CFG, cfg);
        pulse(7, 3);
        pulse(6, 2);
        pulse(5, 2);
        pulse(4, 4);
        pulse(3, 2);
        pulse(2, 3);
        pulse(1, 1);
        pulse(0, 6);
        apb(1'b1, fec_pkg::IDX_ERR_CFG, cfg | 8'h40);
        rd16(fec_pkg::IDX_LCV_HIGH, lcv);
        rd16(fec_pkg::IDX_PCV_HIGH, pcv);
        rd16(fec_pkg::IDX_FOS_HIGH, sync_loss_count_bits);
        rd16(fec_pkg::IDX_EB_HIGH, eb);
    endtask
    task poll(input logic [7:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, fec_pkg::IDX_EB_LOW, 8'h00);
            n++;
        end while (rdat[7:0] !== v && n < 800);
    endtask
    // Polling costs three cycles per read, hence the slack of four
    task interval(input int exp);
        int t0;
        pulse(0, 1);
        poll(8'h01);
        t0 = cyc;
        pulse(0, 2);
        poll(8'h02);
        check(32'((cyc - t0 >= exp - 4) && (cyc - t0 <= exp + 4)), 32'h1);
    endtask
    task path(input int oi, input int si);
        logic [7:0] pv;
        logic [1:0] po;
        repeat (2) @(negedge pclk);
        repeat (4) begin
            pv = sv;
            po = ov[2*oi+:2];
            @(negedge pclk);
            check({30'h0, ov[2*oi+:2]}, {30'h0, (si == 4) ? ~po : pv[2*si+:2]});
        end
    endtask
    task lp(input logic pin, input logic [7:0] ctrl, input logic t1, input int rx_src, input int tx_src);
        @(posedge pclk);
        line_mux_control <= pin;
        t1_mode <= t1;
        apb(1'b1, fec_pkg::IDX_LOOP_CTRL, ctrl);
        path(3, rx_src);
        path(2, tx_src);
        check(line_connected, pin && !ctrl[fec_pkg::BIT_LINE_MUX]);
        check(route.jitter_atten_in_loop, ctrl[fec_pkg::BIT_LOCAL_LOOP]);
        check(route.framer_rx_on_tx_clock, ctrl[fec_pkg::BIT_FRAMER_LOOP]);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 8'h41; i <= 8'h4b; i++) begin
            rd(8'(i), 8'h00);
        end
        apb(1'b0, 8'h4c, 8'h00);
        check(last_err, 1'b1);
        apb(1'b1, fec_pkg::IDX_EB_LOW, 8'h55);
        check(last_err, 1'b1);
        apb(1'b1, fec_pkg::IDX_LOOP_CTRL, 8'hff);
        rd(fec_pkg::IDX_LOOP_CTRL, 8'h1f);
        apb(1'b1, fec_pkg::IDX_CHAN_LOOP_1, 8'ha5);
        rd(fec_pkg::IDX_CHAN_LOOP_1, 8'ha5);
        $display("test registers done");
        round(1'b1, 8'h11, 16'h0005, 16'h0004, 16'h0003, 16'h0006);
        round(1'b1, 8'h16, 16'h0003, 16'h0006, 16'h0001, 16'h0006);
        round(1'b0, 8'h18, 16'h0002, 16'h0004, 16'h0003, 16'h0006);
        round(1'b0, 8'h10, 16'h0003, 16'h0004, 16'h0003, 16'h0006);
        $display("test counters done");
        apb(1'b1, fec_pkg::IDX_ERR_CFG, 8'h10);
        pulse(0, 65540);
        apb(1'b1, fec_pkg::IDX_ERR_CFG, 8'h50);
        rd16(fec_pkg::IDX_EB_HIGH, 16'hffff);
        apb(1'b1, fec_pkg::IDX_ERR_CFG, 8'h10);
        apb(1'b1, fec_pkg::IDX_ERR_CFG, 8'h50);
        rd16(fec_pkg::IDX_EB_HIGH, 16'h0000);
        $display("test saturation done");
        apb(1'b1, fec_pkg::IDX_ERR_CFG, 8'h00);
        interval(50);
        t1_mode <= 1'b1;
        apb(1'b1, fec_pkg::IDX_ERR_CFG, 8'h20);
        interval(666);
        t1_mode <= 1'b0;
        interval(1000);
        $display("test intervals done");
        lp(1'b1, 8'h00, 1'b0, 2, 3);
        lp(1'b0, 8'h00, 1'b0, 1, 0);
        path(1, 3);
        path(0, 2);
        lp(1'b1, 8'h10, 1'b0, 1, 0);
        lp(1'b1, 8'h04, 1'b0, 2, 2);
        lp(1'b1, 8'h08, 1'b0, 3, 3);
        lp(1'b1, 8'h01, 1'b0, 3, 3);
        lp(1'b1, 8'h01, 1'b1, 3, 4);
        t1_mode <= 1'b1;
        apb(1'b1, fec_pkg::IDX_LOOP_CTRL, 8'h02);
        repeat (2) @(negedge pclk);
        check(route.payload_bits, 8'hc0);
        check(route.tx_inputs_ignored, 1'b1);
        check(route.framer_tx_from_rx_clock, 1'b1);
        check(route.overhead_regenerate, 1'b1);
        @(posedge pclk);
        t1_mode <= 1'b0;
        repeat (3) @(negedge pclk);
        check(route.payload_bits, 8'hf8);
        apb(1'b1, fec_pkg::IDX_CHAN_LOOP_1, 8'h01);
        repeat (2) @(negedge pclk);
        check(route.chan_loop, 8'h01);
        $display("test loopback done");
        conclude();
    end
endmodule
